// >>> watchdog_interval_timer.sv
// watchdog / interval timer with apb register access
`timescale 1ns/10ps
`default_nettype none
module watchdog_interval_timer (
  input wire logic clk_in, // 250 MHz system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb enable
  input wire logic pwrite_in, // apb direction
  input wire logic [wdt_pkg::ADDR_W-1:0] paddr_in, // apb byte address
  input wire logic [wdt_pkg::DATA_W-1:0] pwdata_in, // apb write data
  input wire logic [wdt_pkg::STRB_W-1:0] pstrb_in, // apb byte strobes
  input wire logic stop_in, // stop power state
  output logic [wdt_pkg::DATA_W-1:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error
  output logic irq_out, // maskable interrupt from interval and nmi event status bits, level
  output logic nmi_out, // non-maskable interrupt, pulse
  output logic sys_reset_req_out // system reset request, level
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [wdt_pkg::CLKSEL_W-1:0] clksel_reg;
  wdt_pkg::mode_bits_t mode_reg;
  wdt_pkg::mode_bits_t mode_next;
  logic [wdt_pkg::IRQ_W-1:0] status_reg;
  logic [wdt_pkg::IRQ_W-1:0] status_next;
  logic [wdt_pkg::IRQ_W-1:0] mask_reg;
  logic irq_reg;
  logic nmi_reg;
  logic reset_req_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [wdt_pkg::DATA_W-1:0] prdata_reg;
  logic [wdt_pkg::DATA_W-1:0] rdata_mux;
  wdt_pkg::wdt_mode_t mode_sel;
  logic tick;
  logic overflow;
  logic [wdt_pkg::COUNT_W-1:0] count;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire setup = psel_in & ~penable_in;
  wire access = psel_in & penable_in & pready_reg;
  wire wr = access & pwrite_in;
  wire hit_clksel = paddr_in == wdt_pkg::CLKSEL_ADDR;
  wire hit_mode = paddr_in == wdt_pkg::MODE_ADDR;
  wire hit_status = paddr_in == wdt_pkg::IRQ_STATUS_ADDR;
  wire hit_mask = paddr_in == wdt_pkg::IRQ_MASK_ADDR;
  wire hit_timer = paddr_in == wdt_pkg::TIMER_STATUS_ADDR;
  wire hit_any = hit_clksel | hit_mode | hit_status | hit_mask | hit_timer;
  wire lane0 = pstrb_in[0];
  wire wr_clksel = wr & hit_clksel & lane0;
  wire wr_mode = wr & hit_mode & lane0;
  wire wr_status = wr & hit_status & lane0;
  wire wr_mask = wr & hit_mask & lane0;
  wire go_write = wr_mode & pwdata_in[wdt_pkg::RUN_BIT];
  wire wd_write = wr_mode & pwdata_in[wdt_pkg::ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // mode register: bits only ever set by software
  assign mode_next.run = mode_reg.run | (wr_mode & pwdata_in[wdt_pkg::RUN_BIT]);
  assign mode_next.enable = mode_reg.enable | (wr_mode & pwdata_in[wdt_pkg::ENABLE_BIT]);
  assign mode_next.action = mode_reg.action | (wr_mode & pwdata_in[wdt_pkg::ACTION_BIT]);

  always_comb begin
    unique case ({mode_reg.enable, mode_reg.action})
      2'h0: mode_sel = wdt_pkg::MODE_OFF;
      2'h1: mode_sel = wdt_pkg::MODE_INTERVAL;
      2'h2: mode_sel = wdt_pkg::MODE_NMI;
      2'h3: mode_sel = wdt_pkg::MODE_SYS_RESET;
    endcase
  end

  // halt has no effect here; only stop freezes the count
  wire count_en = mode_reg.run & (mode_sel != wdt_pkg::MODE_OFF) & ~stop_in;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and counter
  wdt_prescaler u_prescaler (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .freeze_in(stop_in),
    .sel_in(clksel_reg),
    .tick_out(tick)
  );

  // 128 count clocks of 16..1024 cycles gives 2^11..2^17 cycles
  wdt_counter u_counter (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .clear_in(go_write),
    .count_en_in(count_en),
    .tick_in(tick),
    .count_out(count),
    .overflow_out(overflow)
  );

  ////////////////////////////////////////////////////////////////////////////
  // events and interrupt status
  wire interval_evt = overflow & (mode_sel == wdt_pkg::MODE_INTERVAL);
  wire late_nmi_evt = wd_write & status_reg[wdt_pkg::PEND_BIT];
  wire nmi_evt = (overflow & (mode_sel == wdt_pkg::MODE_NMI)) | late_nmi_evt;
  wire reset_evt = overflow & (mode_sel == wdt_pkg::MODE_SYS_RESET);
  wire [wdt_pkg::IRQ_W-1:0] evt_set = {nmi_evt, interval_evt};
  wire [wdt_pkg::IRQ_W-1:0] evt_clr = wr_status ? pwdata_in[wdt_pkg::IRQ_W-1:0] : '0;

  // a new event beats a same-cycle clear
  assign status_next = (status_reg & ~evt_clr) | evt_set;

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_comb begin
    rdata_mux = '0;
    if (hit_clksel) begin
      rdata_mux[wdt_pkg::CLKSEL_W-1:0] = clksel_reg;
    end
    if (hit_mode) begin
      rdata_mux[wdt_pkg::RUN_BIT] = mode_reg.run;
      rdata_mux[wdt_pkg::ENABLE_BIT] = mode_reg.enable;
      rdata_mux[wdt_pkg::ACTION_BIT] = mode_reg.action;
    end
    if (hit_status) begin
      rdata_mux[wdt_pkg::IRQ_W-1:0] = status_reg;
    end
    if (hit_mask) begin
      rdata_mux[wdt_pkg::IRQ_W-1:0] = mask_reg;
    end
    if (hit_timer) begin
      rdata_mux[wdt_pkg::COUNT_W-1:0] = count;
      rdata_mux[wdt_pkg::RESET_REQ_BIT] = reset_req_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access phase, answer prepared in setup
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~hit_any;
      prdata_reg <= setup ? rdata_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clksel_reg <= wdt_pkg::CLKSEL_RESET;
      mode_reg <= wdt_pkg::MODE_RESET_VAL;
      mask_reg <= wdt_pkg::IRQ_MASK_RESET;
    end else begin
      if (wr_clksel) begin
        clksel_reg <= pwdata_in[wdt_pkg::CLKSEL_W-1:0];
      end
      mode_reg <= mode_next;
      if (wr_mask) begin
        mask_reg <= pwdata_in[wdt_pkg::IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_reg <= wdt_pkg::IRQ_STATUS_RESET;
      irq_reg <= 1'b0;
      nmi_reg <= 1'b0;
      reset_req_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & ~mask_reg);
      nmi_reg <= nmi_evt;
      reset_req_reg <= reset_req_reg | reset_evt;
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign irq_out = irq_reg;
  assign nmi_out = nmi_reg;
  assign sys_reset_req_out = reset_req_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_go_write;
    go_write;
  endsequence

  sequence s_wd_on_pending;
    wd_write ##0 status_reg[wdt_pkg::PEND_BIT];
  endsequence

  property p_legal_tick;
    tick |-> (clksel_reg == wdt_pkg::CLK_DIV16) || (clksel_reg == wdt_pkg::CLK_DIV64)
      || (clksel_reg == wdt_pkg::CLK_DIV256) || (clksel_reg == wdt_pkg::CLK_DIV1024);
  endproperty
  a_legal_tick: assert property (p_legal_tick) else $error("count tick under prohibited code");

  property p_div16_spacing;
    (tick && clksel_reg == wdt_pkg::CLK_DIV16 && !stop_in) ##1 (!stop_in && !wr_clksel)[*8]
      |-> !$past(tick);
  endproperty
  a_div16_spacing: assert property (p_div16_spacing) else $error("divide-by-16 ticks too close");

  property p_go_clears;
    s_go_write |=> count == '0;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("count_go did not clear counter");

  property p_idle_holds;
    !mode_reg.run && !go_write |=> $stable(count);
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("counter moved while stopped");

  property p_run_sticky;
    mode_reg.run |=> mode_reg.run;
  endproperty
  a_run_sticky: assert property (p_run_sticky) else $error("count_go cleared");

  property p_mode_sticky;
    mode_reg.enable || mode_reg.action |=> $past(mode_reg.enable) <= mode_reg.enable
      && $past(mode_reg.action) <= mode_reg.action;
  endproperty
  a_mode_sticky: assert property (p_mode_sticky) else $error("mode bit cleared");

  property p_off_no_count;
    mode_sel == wdt_pkg::MODE_OFF && !go_write |=> $stable(count);
  endproperty
  a_off_no_count: assert property (p_off_no_count) else $error("counter moved with mode off");

  property p_interval_irq;
    interval_evt && !mask_reg[wdt_pkg::PEND_BIT] |=> irq_out && status_reg[wdt_pkg::PEND_BIT];
  endproperty
  a_interval_irq: assert property (p_interval_irq) else $error("interval overflow lost");

  property p_late_nmi;
    s_wd_on_pending |=> nmi_out;
  endproperty
  a_late_nmi: assert property (p_late_nmi) else $error("pending flag did not raise nmi");

  property p_mask_gate;
    (status_reg & ~mask_reg) == '0 && evt_set == '0 |=> !irq_out;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("irq without unmasked status");

  property p_stop_freeze;
    stop_in && !go_write |=> $stable(count);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("counter moved in stop state");

  property p_wrap;
    overflow |=> count == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_nmi_pulse;
    overflow && mode_sel == wdt_pkg::MODE_NMI |=> nmi_out ##1 !nmi_out;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi not a single pulse");

  property p_reset_req;
    reset_evt |=> sys_reset_req_out [*4];
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("reset request not held");

endmodule
`default_nettype wire

// >>> wdt_pkg.sv
// constants, field layouts and types shared by the watchdog interval timer
package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [15:0] CLKSEL_INDEX = 16'hFF42;
  localparam logic [15:0] MODE_INDEX = 16'hFFF9;
  localparam logic [15:0] IRQ_STATUS_INDEX = 16'h0010;
  localparam logic [15:0] IRQ_MASK_INDEX = 16'h0011;
  localparam logic [15:0] TIMER_STATUS_INDEX = 16'h0012;
  localparam logic [ADDR_W-1:0] CLKSEL_ADDR = {2'h0, CLKSEL_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] MODE_ADDR = {2'h0, MODE_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = {2'h0, IRQ_STATUS_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = {2'h0, IRQ_MASK_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] TIMER_STATUS_ADDR = {2'h0, TIMER_STATUS_INDEX, 2'h0};

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int unsigned CLKSEL_W = 3;
  localparam int unsigned RUN_BIT = 7;
  localparam int unsigned ENABLE_BIT = 4;
  localparam int unsigned ACTION_BIT = 3;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned PEND_BIT = 0;
  localparam int unsigned NMI_EVT_BIT = 1;
  localparam int unsigned RESET_REQ_BIT = 8;
  localparam logic [CLKSEL_W-1:0] CLKSEL_RESET = 3'h0;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // count clock selection and counter geometry
  localparam logic [CLKSEL_W-1:0] CLK_DIV16 = 3'h0;
  localparam logic [CLKSEL_W-1:0] CLK_DIV64 = 3'h2;
  localparam logic [CLKSEL_W-1:0] CLK_DIV256 = 3'h4;
  localparam logic [CLKSEL_W-1:0] CLK_DIV1024 = 3'h6;
  localparam int unsigned PRESCALE_W = 10;
  localparam int unsigned DIV16_MSB = 3;
  localparam int unsigned DIV64_MSB = 5;
  localparam int unsigned DIV256_MSB = 7;
  localparam int unsigned DIV1024_MSB = 9;
  localparam int unsigned COUNT_W = 7;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 7'h7F;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic run;
    logic enable;
    logic action;
  } mode_bits_t;

  localparam mode_bits_t MODE_RESET_VAL = 3'h0;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_INTERVAL,
    MODE_NMI,
    MODE_SYS_RESET
  } wdt_mode_t;

endpackage

// >>> wdt_prescaler.sv
// free-running system clock prescaler producing the selected count enable
`timescale 1ns/10ps
`default_nettype none
module wdt_prescaler (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic freeze_in, // stop power state
  input wire logic [wdt_pkg::CLKSEL_W-1:0] sel_in, // count clock select
  output logic tick_out // one-cycle count enable
);

  logic [wdt_pkg::PRESCALE_W-1:0] div_reg;
  logic [wdt_pkg::PRESCALE_W-1:0] div_next;
  wire wrap16 = &div_reg[wdt_pkg::DIV16_MSB:0];
  wire wrap64 = &div_reg[wdt_pkg::DIV64_MSB:0];
  wire wrap256 = &div_reg[wdt_pkg::DIV256_MSB:0];
  wire wrap1024 = &div_reg[wdt_pkg::DIV1024_MSB:0];

  // phase is never cleared on restart, so first period may run short
  assign div_next = freeze_in ? div_reg : div_reg + 10'h001;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // prohibited codes give no count enable at all
  always_comb begin
    unique case (sel_in)
      wdt_pkg::CLK_DIV16: tick_out = wrap16 & ~freeze_in;
      wdt_pkg::CLK_DIV64: tick_out = wrap64 & ~freeze_in;
      wdt_pkg::CLK_DIV256: tick_out = wrap256 & ~freeze_in;
      wdt_pkg::CLK_DIV1024: tick_out = wrap1024 & ~freeze_in;
      default: tick_out = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// >>> wdt_counter.sv
// seven-bit watchdog count with clear and overflow
`timescale 1ns/10ps
`default_nettype none
module wdt_counter (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic clear_in, // restart from zero
  input wire logic count_en_in, // counting allowed
  input wire logic tick_in, // count clock enable
  output logic [wdt_pkg::COUNT_W-1:0] count_out, // current count
  output logic overflow_out // one-cycle overflow
);

  logic [wdt_pkg::COUNT_W-1:0] count_reg;
  logic [wdt_pkg::COUNT_W-1:0] count_next;
  wire step = count_en_in & tick_in;

  // wraps to zero and keeps counting
  assign overflow_out = step & ~clear_in & (count_reg == wdt_pkg::COUNT_MAX);
  assign count_next = clear_in ? '0 : (step ? count_reg + 7'h01 : count_reg);
  assign count_out = count_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

endmodule
`default_nettype wire

// >>> wdt_far_side.sv
// far-side model: interrupt controller and system reset logic
`timescale 1ns/10ps
`default_nettype none
module wdt_far_side (
  input wire logic clk_in, // system clock
  input wire logic irq_in, // level interrupt
  input wire logic nmi_in, // non-maskable pulse
  input wire logic reset_req_in, // system reset request
  output var int nmi_count_out, // pulses taken
  output var int irq_rise_out, // cycle of last irq rise
  output var logic reset_seen_out // reset request seen
);
  int cyc = 0;
  logic irq_q = 1'b0;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    irq_q <= irq_in;
    if (nmi_in === 1'b1) begin
      nmi_count_out <= nmi_count_out + 1;
    end
    if (irq_in === 1'b1 && irq_q !== 1'b1) begin
      irq_rise_out <= cyc;
    end
    reset_seen_out <= (reset_req_in === 1'b1);
  end
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the watchdog interval timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stop = 1'b0;
  logic [wdt_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, nmi, rreq, rseen;
  int nmi_n, irq_rise;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;

  always #2 clk_in = ~clk_in;

  watchdog_interval_timer dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .stop_in(stop), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .irq_out(irq), .nmi_out(nmi), .sys_reset_req_out(rreq)
  );
  wdt_far_side far (
    .clk_in(clk_in), .irq_in(irq), .nmi_in(nmi), .reset_req_in(rreq),
    .nmi_count_out(nmi_n), .irq_rise_out(irq_rise), .reset_seen_out(rseen)
  );

  ////////////////////////////////////////
  task automatic finish_test;
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [wdt_pkg::ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_in);
    penable <= 1'b1;
    @(posedge clk_in);
    // values seen here are those sampled at this edge; only the bench timeout ends the wait
    while (pready !== 1'b1) begin
      @(posedge clk_in);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdr(input logic [wdt_pkg::ADDR_W-1:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  task automatic do_reset;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    stop <= 1'b0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
  endtask

  task automatic wait_irq(input int lim, output int n);
    n = 0;
    #1;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_in);
      #1;
      n++;
    end
  endtask

  ////////////////////////////////////////
  task automatic t_regs;
    rdr(wdt_pkg::CLKSEL_ADDR);
    check(rd, 32'h0);
    rdr(wdt_pkg::MODE_ADDR);
    check(rd, 32'h0);
    rdr(wdt_pkg::IRQ_MASK_ADDR);
    check(rd, 32'h3);
    rdr(20'h00100);
    check({31'h0, err}, 32'h1);
    for (int i = 0; i < 8; i += 2) begin
      apb(1'b1, wdt_pkg::CLKSEL_ADDR, 32'(i), 4'h1);
      rdr(wdt_pkg::CLKSEL_ADDR);
      check(rd, 32'(i));
    end
    apb(1'b1, wdt_pkg::CLKSEL_ADDR, 32'h2, 4'h0);
    rdr(wdt_pkg::CLKSEL_ADDR);
    check(rd, 32'h6);
    // run set with mode bits 00: no counting
    apb(1'b1, wdt_pkg::CLKSEL_ADDR, 32'h0, 4'h1);
    apb(1'b1, wdt_pkg::MODE_ADDR, 32'h80, 4'h1);
    repeat (100) @(posedge clk_in);
    rdr(wdt_pkg::TIMER_STATUS_ADDR);
    check(rd, 32'h0);
  endtask

  task automatic t_interval(input logic [2:0] code, input int period);
    int n;
    int r1;
    do_reset();
    apb(1'b1, wdt_pkg::CLKSEL_ADDR, {29'h0, code}, 4'h1);
    apb(1'b1, wdt_pkg::IRQ_MASK_ADDR, 32'h0, 4'hF);
    apb(1'b1, wdt_pkg::MODE_ADDR, 32'h88, 4'h1);
    wait_irq(period + 50, n);
    check({31'h0, n >= period - period / 128 && n <= period + 4}, 32'h1);
    // far side logs the rise one edge later
    @(posedge clk_in);
    #1;
    r1 = irq_rise;
    apb(1'b1, wdt_pkg::IRQ_STATUS_ADDR, 32'h1, 4'h1);
    repeat (2) @(posedge clk_in);
    #1;
    check({31'h0, irq}, 32'h0);
    wait_irq(period + 50, n);
    repeat (2) @(posedge clk_in);
    check(32'(irq_rise - r1), 32'(period));
    apb(1'b1, wdt_pkg::MODE_ADDR, 32'h0, 4'h1);
    rdr(wdt_pkg::MODE_ADDR);
    check(rd, 32'h88);
    apb(1'b1, wdt_pkg::IRQ_MASK_ADDR, 32'h1, 4'h1);
    repeat (2) @(posedge clk_in);
    #1;
    check({31'h0, irq}, 32'h0);
  endtask

  // pending flag left set by the interval run
  task automatic t_pending_nmi;
    int n0;
    int n;
    n0 = nmi_n;
    apb(1'b1, wdt_pkg::MODE_ADDR, 32'h10, 4'h1);
    repeat (3) @(posedge clk_in);
    check(32'(nmi_n - n0), 32'h1);
    rdr(wdt_pkg::MODE_ADDR);
    check(rd, 32'h98);
    n = 0;
    while (rseen !== 1'b1 && n < 2200) begin
      @(posedge clk_in);
      n++;
    end
    check({31'h0, rseen}, 32'h1);
    rdr(wdt_pkg::TIMER_STATUS_ADDR);
    check(rd & 32'h100, 32'h100);
  endtask

  task automatic t_nmi;
    int n0;
    do_reset();
    apb(1'b1, wdt_pkg::MODE_ADDR, 32'h90, 4'h1);
    n0 = nmi_n;
    repeat (3) begin
      repeat (1500) @(posedge clk_in);
      apb(1'b1, wdt_pkg::MODE_ADDR, 32'h80, 4'h1);
    end
    check(32'(nmi_n - n0), 32'h0);
    repeat (4150) @(posedge clk_in);
    #1;
    check(32'(nmi_n - n0), 32'h2);
    check({31'h0, rreq}, 32'h0);
  endtask

  task automatic t_stop;
    logic [31:0] c1;
    do_reset();
    apb(1'b1, wdt_pkg::MODE_ADDR, 32'h08, 4'h1);
    repeat (200) @(posedge clk_in);
    rdr(wdt_pkg::TIMER_STATUS_ADDR);
    check(rd, 32'h0);
    apb(1'b1, wdt_pkg::MODE_ADDR, 32'h80, 4'h1);
    repeat (100) @(posedge clk_in);
    stop <= 1'b1;
    rdr(wdt_pkg::TIMER_STATUS_ADDR);
    c1 = rd;
    repeat (300) @(posedge clk_in);
    rdr(wdt_pkg::TIMER_STATUS_ADDR);
    check(rd, c1);
    stop <= 1'b0;
    repeat (100) @(posedge clk_in);
    rdr(wdt_pkg::TIMER_STATUS_ADDR);
    check({31'h0, rd !== c1}, 32'h1);
    // prohibited clock code: count must hold
    apb(1'b1, wdt_pkg::CLKSEL_ADDR, 32'h1, 4'h1);
    rdr(wdt_pkg::TIMER_STATUS_ADDR);
    c1 = rd;
    repeat (100) @(posedge clk_in);
    rdr(wdt_pkg::TIMER_STATUS_ADDR);
    check(rd, c1);
  endtask

  initial begin
    do_reset();
    t_regs();
    t_interval(3'h0, 2048);
    t_pending_nmi();
    t_interval(3'h2, 8192);
    t_nmi();
    t_stop();
    finish_test();
  end
endmodule
`default_nettype wire
